// ---- design/tpsr_consts.svh ----
// Offsets, field positions, reset values and timing counts of the transmit path selector.
`ifndef TPSR_CONSTS_SVH
`define TPSR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------------
`define TPSR_ADDR_CTRL      8'h00
`define TPSR_ADDR_STATUS    8'h04
`define TPSR_ADDR_STRAPS    8'h08
`define TPSR_ADDR_LEVEL     8'h0C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TPSR_CTRL_SETUP_END 0
`define TPSR_CTRL_USB_EN    1
`define TPSR_CTRL_RESET     32'h0000_0002

// ----------------------------------------------------------------------------
// Timing and buffer figures
// ----------------------------------------------------------------------------
`define TPSR_CLK_PERIOD_NS  40
`define TPSR_INIT_TIME_NS   100000
`define TPSR_INIT_CYCLES    ((`TPSR_INIT_TIME_NS + `TPSR_CLK_PERIOD_NS - 1) / `TPSR_CLK_PERIOD_NS)
`define TPSR_BUSY_SET_FREE  12'h03E
`define TPSR_BUSY_CLR_FREE  12'h080
`define TPSR_I2C_BASE_ADDR  7'h50
`define TPSR_FIFO_DEPTH     32

`endif

// ---- design/tpsr_fifo.sv ----
// Transmit byte FIFO with valid/ready on both sides and a registered head word.
`timescale 1ns/1ns
`default_nettype none

module tpsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic             wrValid,
  output logic                  wrReady,
  output logic [WIDTH-1:0]      rdData,
  output logic                  rdValid,
  input  wire logic             rdReady,
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [CW-1:0]    count_q;
  logic [WIDTH-1:0] head_q;
  logic             headValid_q;
  logic             push;
  logic             pull;
  logic [CW-1:0]    countNext;
  logic             notFull_q;

  // Full is honest: the array alone is counted, the head register is extra slack.
  // Ready comes from a flop loaded from the next count, so it reaches the
  // top-level pin without a comparator in front of it.
  assign wrReady   = notFull_q;
  assign countNext = CW'(count_q + CW'(push) - CW'(pull));
  assign push    = wrValid & wrReady;
  assign pull    = (count_q != '0) & (~headValid_q | rdReady);
  assign rdData  = head_q;
  assign rdValid = headValid_q;
  assign level   = count_q;

  // Storage array write.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= wrData;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q   <= '0;
      notFull_q <= 1'b1;
    end else begin
      if (push) wrPtr_q <= AW'(wrPtr_q + 1'b1);
      if (pull) rdPtr_q <= AW'(rdPtr_q + 1'b1);
      count_q   <= countNext;
      notFull_q <= (countNext != CW'(DEPTH));
    end
  end

  // Head register; read data always comes from this flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      head_q      <= '0;
      headValid_q <= 1'b0;
    end else if (pull) begin
      head_q      <= mem[rdPtr_q];
      headValid_q <= 1'b1;
    end else if (rdReady) begin
      headValid_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- design/tpsr_pkg.sv ----
// Types shared by the transmit path selector files.
package tpsr_pkg;

  // Transmit path states, one-hot.
  typedef enum logic [2:0] {
    PATH_SERIAL = 3'b001,
    PATH_USB    = 3'b010,
    PATH_LOCKED = 3'b100
  } tpsr_path_e;

  // Serial protocol chosen by the mode straps, one-hot.
  typedef enum logic [2:0] {
    MODE_UART = 3'b001,
    MODE_SPI  = 3'b010,
    MODE_I2C  = 3'b100
  } tpsr_mode_e;

endpackage

// ---- design/tpsr_top.sv ----
// Transmit path selector with module reset, busy flag and strap decode.
// Summary of operation
// - After reset, transmit on strap-selected serial port.
// - Configured USB plus endpoint-1 bulk-IN selects USB.
// - Later serial byte locks path to serial.
// - Lock clears on reset, power, setup end.
// - Low reset pin holds all logic but the strap capture initial.
// - Busy shown during init after reset release.
// - Open strap reads high, shorted reads low.
// - Two mode straps pick one serial protocol.
// - Busy at 62 free, ready at 128.
// - Pending output high while transmit buffer holds data.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tpsr_consts.svh"

module tpsr_top #(
  parameter int INIT_CYCLES = `TPSR_INIT_CYCLES,
  parameter int FIFO_DEPTH  = `TPSR_FIFO_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Module reset pin and strap pins, asynchronous to ref_clk.
  input  wire logic        moduleResetN,
  input  wire logic        slave_addr_strap_a,
  input  wire logic        slave_addr_strap_b,
  input  wire logic        baud_strap_a,
  input  wire logic        baud_strap_b,
  input  wire logic        serial_mode_strap_a,
  input  wire logic        serial_mode_strap_b,
  input  wire logic        macro_autorun_strap,
  input  wire logic        touch_calibration_strap,
  // Events from the link cores, on ref_clk.
  input  wire logic        usbConfigured,
  input  wire logic        usbBulkInEp1,
  input  wire logic        serialRxByte,
  input  wire logic        setupEndCmd,
  input  wire logic [11:0] rxFreeSpace,
  // Outgoing bytes from the display logic.
  input  wire logic [7:0]  txData,
  input  wire logic        txValid,
  output logic             txReady,
  // Serial link sink.
  output logic [7:0]       serialTxData,
  output logic             serialTxValid,
  input  wire logic        serialTxReady,
  // USB bulk-IN sink.
  output logic [7:0]       usbTxData,
  output logic             usbTxValid,
  input  wire logic        usbTxReady,
  // Pin-level status.
  output logic             display_busy_out,
  output logic             transmit_pending_out,
  output logic             initBusy,
  output logic             usbPathSelected,
  output logic [2:0]       serialMode,
  output logic [6:0]       i2cSlaveAddr,
  output logic [1:0]       baudSel,
  output logic             macroAutorun,
  output logic             touchCalibration,
  // Register port.
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdData
);

  localparam int LW = $clog2(FIFO_DEPTH + 1);
  localparam int IW = $clog2(INIT_CYCLES + 1);

  // --------------------------------------------------------------------------
  // Pin synchronisers and internal reset
  // --------------------------------------------------------------------------
  logic [8:0] pinMeta_q;
  logic [8:0] pinSync_q;
  logic       rst;
  logic       rstDly_q;

  // Two flops per pin; only the second stage feeds any logic.
  // Clearing both stages under system reset makes the pin reset read as held
  // until two clean edges have passed, so no logic leaves reset on a stale
  // sample. The straps share the pipeline and become valid on the same edge.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinMeta_q <= 9'h000;
      pinSync_q <= 9'h000;
    end else begin
      pinMeta_q <= {moduleResetN, slave_addr_strap_a, slave_addr_strap_b, baud_strap_a,
                    baud_strap_b, serial_mode_strap_a, serial_mode_strap_b,
                    macro_autorun_strap, touch_calibration_strap};
      pinSync_q <= pinMeta_q;
    end
  end

  // Holding the pin low keeps every flop below at its initial value, except the strap capture straps_q.
  assign rst = sys_rst | ~pinSync_q[8];

  // Delayed copy of reset marks the release edge.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rstDly_q <= 1'b1;
    end else begin
      rstDly_q <= rst;
    end
  end

  // --------------------------------------------------------------------------
  // Initialisation interval
  // --------------------------------------------------------------------------
  logic [IW-1:0] initCnt_q;
  logic          init_q;

  // Counts out the not-ready interval that follows every reset release.
  // The count reloads on every reset cycle, so a pin held low for a long time
  // still gives the full interval once it is let go.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      initCnt_q <= IW'(INIT_CYCLES);
      init_q    <= 1'b1;
    end else if (initCnt_q != '0) begin
      initCnt_q <= IW'(initCnt_q - 1'b1);
      init_q    <= 1'b1;
    end else begin
      init_q    <= 1'b0;
    end
  end

  // Received bytes are not accepted during init, nor do they steer the path.
  // The host is expected to wait for ready, so such a byte is a host fault.
  logic rxSeen;
  assign rxSeen = serialRxByte & ~init_q;

  // --------------------------------------------------------------------------
  // Strap capture and decode
  // --------------------------------------------------------------------------
  logic [7:0] straps_q;

  // Straps are caught once, at the first edge after reset release, so a
  // jumper moved while running has no effect until the next reset.
  // A pin reset alone keeps the old capture until its release takes a new one.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      straps_q <= 8'hFF;  // All jumpers open by default.
    end else if (rstDly_q & ~rst) begin
      straps_q <= pinSync_q[7:0];
    end
  end

  // Decoded strap outputs; a shorted jumper reads low and means asserted.
  // Decoding from the captured copy keeps the outputs steady while a jumper
  // is being moved.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serialMode       <= tpsr_pkg::MODE_SPI;
      i2cSlaveAddr     <= `TPSR_I2C_BASE_ADDR;
      baudSel          <= 2'h0;
      macroAutorun     <= 1'b0;
      touchCalibration <= 1'b0;
    end else begin
      unique case (straps_q[3:2])
        2'b00: serialMode <= tpsr_pkg::MODE_UART;
        2'b11: serialMode <= tpsr_pkg::MODE_SPI;
        2'b01: serialMode <= tpsr_pkg::MODE_I2C;
        2'b10: serialMode <= tpsr_pkg::MODE_UART;  // Unassigned code falls back to UART.
      endcase
      i2cSlaveAddr     <= 7'(`TPSR_I2C_BASE_ADDR + {5'h00, ~straps_q[6], ~straps_q[7]});
      baudSel          <= {~straps_q[4], ~straps_q[5]};
      macroAutorun     <= ~straps_q[1];
      touchCalibration <= ~straps_q[0];
    end
  end

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  logic           usbEnable_q;
  logic           setupEnd;
  tpsr_pkg::tpsr_path_e path_q;
  logic [LW-1:0]  fifoLevel;

  // Software may forbid the USB path; the setup-end bit acts only on write.
  assign setupEnd = setupEndCmd |
                    (regWr & (regAddr == `TPSR_ADDR_CTRL) & regWrData[`TPSR_CTRL_SETUP_END]);

  // Control register write.
  // Only the enable bit is stored; the setup-end bit is a strobe.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      usbEnable_q <= 1'(`TPSR_CTRL_RESET >> `TPSR_CTRL_USB_EN);
    end else if (regWr & (regAddr == `TPSR_ADDR_CTRL)) begin
      usbEnable_q <= regWrData[`TPSR_CTRL_USB_EN];
    end
  end

  // Read data stand in the cycle after the strobe and read zero otherwise.
  // Returning zero between reads keeps a stale word from being mistaken for
  // a fresh answer by a master that samples one cycle late.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        `TPSR_ADDR_CTRL:   regRdData <= {30'h0, usbEnable_q, 1'b0};
        `TPSR_ADDR_STATUS: regRdData <= {24'h0, usbConfigured, transmit_pending_out,
                                         display_busy_out, init_q, 1'b0, path_q};
        `TPSR_ADDR_STRAPS: regRdData <= {24'h0, straps_q};
        `TPSR_ADDR_LEVEL:  regRdData <= 32'(fifoLevel);
        default:           regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Transmit path state machine
  // --------------------------------------------------------------------------
  logic usbReq;

  // A bulk-IN request counts only once enumeration has configured the link.
  assign usbReq = usbBulkInEp1 & usbConfigured & usbEnable_q;

  // Serial is the reset path; USB is taken on a read, serial locks back until reset or setup end.
  // A serial byte in the same cycle as a bulk-IN request wins, so a host that
  // talks over the serial port never has its replies moved away from it.
  // Losing enumeration while on USB falls back to serial without locking.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      path_q <= tpsr_pkg::PATH_SERIAL;
    end else begin
      unique case (path_q)
        tpsr_pkg::PATH_SERIAL: begin
          if (usbReq & ~rxSeen) begin
            path_q <= tpsr_pkg::PATH_USB;
          end
        end
        tpsr_pkg::PATH_USB: begin
          if (rxSeen) begin
            path_q <= tpsr_pkg::PATH_LOCKED;
          end else if (~usbConfigured) begin
            path_q <= tpsr_pkg::PATH_SERIAL;  // Link lost: serial again.
          end
        end
        tpsr_pkg::PATH_LOCKED: begin
          if (setupEnd) begin
            path_q <= tpsr_pkg::PATH_SERIAL;
          end
        end
        default: path_q <= tpsr_pkg::PATH_SERIAL;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Transmit buffer and output stage
  // --------------------------------------------------------------------------
  logic [7:0] fifoData;
  logic       fifoValid;
  logic       fifoTake;
  logic       outFree;

  tpsr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) txFifo (
    .clk     (ref_clk),
    .rst     (rst),
    .wrData  (txData),
    .wrValid (txValid),
    .wrReady (txReady),
    .rdData  (fifoData),
    .rdValid (fifoValid),
    .rdReady (fifoTake),
    .level   (fifoLevel)
  );

  // The output stage refills only when empty or being drained, so a stalled
  // sink backs up through the FIFO to txReady.
  assign outFree  = (~serialTxValid | serialTxReady) & (~usbTxValid | usbTxReady);
  assign fifoTake = outFree;

  // Each byte is bound to the path that is current when it leaves the FIFO.
  // A path change therefore never splits a byte, but a byte already waiting
  // in the output stage still leaves on the link it was bound to.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serialTxData  <= 8'h00;
      serialTxValid <= 1'b0;
      usbTxData     <= 8'h00;
      usbTxValid    <= 1'b0;
    end else if (outFree) begin
      serialTxData  <= fifoData;
      usbTxData     <= fifoData;
      serialTxValid <= fifoValid & (path_q != tpsr_pkg::PATH_USB);
      usbTxValid    <= fifoValid & (path_q == tpsr_pkg::PATH_USB);
    end
  end

  // --------------------------------------------------------------------------
  // Status pins
  // --------------------------------------------------------------------------
  logic rxBusy_q;

  // Hysteresis on receive space avoids chatter around one threshold.
  // Between the two thresholds the flag keeps its last value.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxBusy_q <= 1'b0;
    end else if (rxFreeSpace <= `TPSR_BUSY_SET_FREE) begin
      rxBusy_q <= 1'b1;
    end else if (rxFreeSpace >= `TPSR_BUSY_CLR_FREE) begin
      rxBusy_q <= 1'b0;
    end
  end

  // Busy pin: high through init and while receive space is short; the host
  // is trusted to hold off data until it drops.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      display_busy_out <= 1'b1;
      initBusy         <= 1'b1;
    end else begin
      display_busy_out <= init_q | rxBusy_q;
      initBusy         <= init_q;
    end
  end

  // Pending is high while any byte sits in the FIFO or the output stage.
  // The head register is counted too; otherwise pending would drop for one
  // cycle while the last byte moves from the array to the output stage.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      transmit_pending_out <= 1'b0;
      usbPathSelected      <= 1'b0;
    end else begin
      transmit_pending_out <= (fifoLevel != '0) | fifoValid | serialTxValid | usbTxValid;
      usbPathSelected      <= (path_q == tpsr_pkg::PATH_USB);
    end
  end

endmodule

`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking testbench for the transmit path selector.
`timescale 1ns/1ns
`default_nettype none
`include "tpsr_consts.svh"
module tb;
  localparam int INIT = 8;
  typedef struct packed {
    logic [7:0] straps;
    logic [2:0] mode;
    logic [6:0] addr;
    logic [1:0] baud;
  } tpsr_row_s;
  logic        refClk, sysRst, modResetN, usbConf, txValid, txReady, regWr, regRd, stall;
  logic        serValid, serReady, usbValid, usbReady, busy, pending, initBusy, usbSel;
  logic        macro, touch;
  logic [2:0]  ev, mode;
  logic [7:0]  straps, txData, serData, usbData, regAddr, lastByte;
  logic [11:0] rxFree;
  logic [6:0]  addr;
  logic [1:0]  baud;
  logic [31:0] regWrData, regRdData, rd;
  logic [15:0] serCnt, usbCnt;
  int          errors, n_checks;
  tpsr_row_s   rows [4] = '{'{8'hFF, 3'b010, 7'h50, 2'b00}, '{8'h51, 3'b001, 7'h51, 2'b01},
                            '{8'hA6, 3'b100, 7'h52, 2'b10}, '{8'h08, 3'b001, 7'h53, 2'b11}};

  tpsr_top #(.INIT_CYCLES(INIT)) i_dut (.ref_clk(refClk), .sys_rst(sysRst),
    .moduleResetN(modResetN), .slave_addr_strap_a(straps[7]), .slave_addr_strap_b(straps[6]),
    .baud_strap_a(straps[5]), .baud_strap_b(straps[4]), .serial_mode_strap_a(straps[3]),
    .serial_mode_strap_b(straps[2]), .macro_autorun_strap(straps[1]),
    .touch_calibration_strap(straps[0]), .usbConfigured(usbConf), .usbBulkInEp1(ev[0]),
    .serialRxByte(ev[1]), .setupEndCmd(ev[2]), .rxFreeSpace(rxFree), .txData(txData),
    .txValid(txValid), .txReady(txReady), .serialTxData(serData), .serialTxValid(serValid),
    .serialTxReady(serReady), .usbTxData(usbData), .usbTxValid(usbValid),
    .usbTxReady(usbReady), .display_busy_out(busy), .transmit_pending_out(pending),
    .initBusy(initBusy), .usbPathSelected(usbSel), .serialMode(mode), .i2cSlaveAddr(addr),
    .baudSel(baud), .macroAutorun(macro), .touchCalibration(touch), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  tpsr_host_model i_host (.ref_clk(refClk), .stall(stall), .serialTxData(serData),
    .serialTxValid(serValid), .serialTxReady(serReady), .usbTxData(usbData),
    .usbTxValid(usbValid), .usbTxReady(usbReady), .serCnt(serCnt), .usbCnt(usbCnt),
    .lastByte(lastByte));

  // Free-running 25 MHz clock.
  initial begin
    refClk = 1'b0;
    forever #20 refClk = ~refClk;
  end

  // Compare one value and count it; unknowns never match.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge refClk);
    #1;
  endtask
  task automatic pulse(input int i);
    @(posedge refClk) ev[i] <= 1'b1;
    @(posedge refClk) ev[i] <= 1'b0;
    tick(2);
  endtask
  // The host sends a byte once the display reports ready, or after a bounded wait of 200 cycles.
  task automatic hostByte();
    for (int k = 0; k < 200 && busy !== 1'b0; k++) tick(1);
    pulse(1);
  endtask
  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge refClk) begin regRd <= 1'b1; regAddr <= a; end
    @(posedge refClk) regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge refClk) begin regWr <= 1'b1; regAddr <= a; regWrData <= d; end
    @(posedge refClk) regWr <= 1'b0;
    #1;
  endtask
  // Hold the byte until the design takes it; give up after a bounded wait.
  task automatic sendByte(input logic [7:0] b);
    int k;
    k = 0;
    @(posedge refClk) begin txValid <= 1'b1; txData <= b; end
    #1;
    while (txReady !== 1'b1 && k < 200) begin tick(1); k++; end
    @(posedge refClk) txValid <= 1'b0;
    #1;
  endtask
  task automatic waitInit(output int k);
    for (k = 0; k < 100 && initBusy !== 1'b0; k++) tick(1);
  endtask
  // Pull the module reset pin low long enough to pass the synchroniser.
  task automatic resetPin();
    int k;
    @(posedge refClk) modResetN <= 1'b0;
    repeat (4) @(posedge refClk);
    modResetN <= 1'b1;
    #1 check("initBusy", initBusy, 1);
    check("busy", busy, 1);
    waitInit(k);
    check("init long", k >= INIT, 1);
    tick(4);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the whole sequence needs a few hundred cycles.
  initial begin
    repeat (20000) @(posedge refClk);
    errors++;
    stop_test();
  end

  // Main sequence: strap table first, then hysteresis, buffer, path and reset cases.
  initial begin
    int k, n;
    logic [15:0] c;
    static logic [11:0] fr [4] = '{12'd63, 12'd62, 12'd127, 12'd128};
    static logic bz [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    {sysRst, modResetN, usbConf, txValid, regWr, regRd, stall} = 7'b1100000;
    {straps, ev, txData, regAddr, regWrData} = '0;
    straps = 8'hFF;
    rxFree = 12'd200;
    errors = 0;
    n_checks = 0;
    repeat (5) @(posedge refClk);
    sysRst <= 1'b0;
    waitInit(k);
    foreach (rows[r]) begin
      @(posedge refClk) straps <= rows[r].straps;
      resetPin();
      check("busy", busy, 0);
      check("mode", mode, rows[r].mode);
      check("addr", addr, rows[r].addr);
      check("baud", baud, rows[r].baud);
      check("flags", {macro, touch}, 2'(~rows[r].straps[1:0]));
      regRead(`TPSR_ADDR_STRAPS, rd);
      check("straps", rd[7:0], rows[r].straps);
      check("usbSel", usbSel, 0);
    end
    // Receive-buffer hysteresis.
    foreach (fr[i]) begin
      @(posedge refClk) rxFree <= fr[i];
      tick(4);
      check("busy", busy, bz[i]);
    end
    // Fill the FIFO against a stalled host, then drain it.
    @(posedge refClk) stall <= 1'b1;
    c = serCnt;
    for (n = 0; n < 40 && txReady === 1'b1; n++) sendByte(n[7:0]);
    regRead(`TPSR_ADDR_LEVEL, rd);
    check("level", rd, `TPSR_FIFO_DEPTH);
    check("pending", pending, 1);
    @(posedge refClk) stall <= 1'b0;
    for (k = 0; k < 200 && pending !== 1'b0; k++) tick(1);
    check("serial count", serCnt - c, n);
    check("last byte", lastByte, n - 1);
    regRead(8'h10, rd);
    check("unmapped", rd, 0);
    // Lock, then clear it by command pin, control write and pin reset in turn.
    @(posedge refClk) usbConf <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      pulse(0);
      check("usbSel", usbSel, 1);
      c = usbCnt;
      sendByte(8'hA5);
      for (k = 0; k < 50 && usbCnt === c; k++) tick(1);
      check("usb count", usbCnt - c, 1);
      check("usb byte", lastByte, 8'hA5);
      hostByte();
      check("usbSel", usbSel, 0);
      pulse(0);
      check("usbSel", usbSel, 0);
      regRead(`TPSR_ADDR_STATUS, rd);
      check("path", rd[2:0], 3'b100);
      if (m == 0) pulse(2);
      else if (m == 1) regWrite(`TPSR_ADDR_CTRL, `TPSR_CTRL_RESET | 32'h1);
      else resetPin();
      pulse(0);
      check("usbSel", usbSel, 1);
    end
    @(posedge refClk) usbConf <= 1'b0;
    tick(4);
    check("usbSel", usbSel, 0);
    pulse(0);
    check("usbSel", usbSel, 0);
    // Software may forbid the USB path even on a configured link.
    regRead(`TPSR_ADDR_CTRL, rd);
    check("ctrl", rd, `TPSR_CTRL_RESET);
    regWrite(`TPSR_ADDR_CTRL, 32'h0000_0000);
    @(posedge refClk) usbConf <= 1'b1;
    tick(2);
    pulse(0);
    check("usbSel", usbSel, 0);
    // System reset with bytes waiting: buffered data is discarded.
    @(posedge refClk) stall <= 1'b1;
    for (n = 0; n < 3; n++) sendByte(8'h3C);
    @(posedge refClk) sysRst <= 1'b1;
    tick(2);
    check("pending", pending, 0);
    check("serValid", serValid, 0);
    check("busy", busy, 1);
    c = serCnt;
    @(posedge refClk) begin sysRst <= 1'b0; stall <= 1'b0; end
    waitInit(k);
    tick(4);
    check("discarded", serCnt, c);
    stop_test();
  end
endmodule
`default_nettype wire

// ---- verification/tpsr_host_model.sv ----
// Host-side sink model for the serial and USB transmit streams.
`timescale 1ns/1ns
`default_nettype none
module tpsr_host_model (
  input  wire logic       ref_clk,
  input  wire logic       stall,
  input  wire logic [7:0] serialTxData,
  input  wire logic       serialTxValid,
  output logic            serialTxReady,
  input  wire logic [7:0] usbTxData,
  input  wire logic       usbTxValid,
  output logic            usbTxReady,
  output logic [15:0]     serCnt,
  output logic [15:0]     usbCnt,
  output logic [7:0]      lastByte
);
  // Both links take bytes at once unless the bench asks for a stall.
  assign serialTxReady = !stall;
  assign usbTxReady    = !stall;

  // Count accepted bytes per link so the bench can tell which path carried them.
  initial begin
    serCnt   = 16'h0000;
    usbCnt   = 16'h0000;
    lastByte = 8'h00;
  end
  always @(posedge ref_clk) begin
    if (serialTxValid && serialTxReady) begin
      serCnt   <= serCnt + 16'h0001;
      lastByte <= serialTxData;
    end
    if (usbTxValid && usbTxReady) begin
      usbCnt   <= usbCnt + 16'h0001;
      lastByte <= usbTxData;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tpsr_monitor.sv ----
// Concurrent checks on the ports of the transmit path selector.
`timescale 1ns/1ns
`default_nettype none
module tpsr_monitor (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        moduleResetN,
  input wire logic [11:0] rxFreeSpace,
  input wire logic        initBusy,
  input wire logic        display_busy_out,
  input wire logic        transmit_pending_out,
  input wire logic [7:0]  serialTxData,
  input wire logic        serialTxValid,
  input wire logic        serialTxReady,
  input wire logic        usbTxValid,
  input wire logic        usbPathSelected,
  input wire logic        usbConfigured,
  input wire logic        serialRxByte,
  input wire logic        setupEndCmd,
  input wire logic        regWr,
  input wire logic [2:0]  serialMode
);
  // Checks pause while the pin reset is low, since the synchroniser delays its effect.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !moduleResetN);

  // A serial byte arriving while USB carries the data.
  sequence lockSeq;
    usbPathSelected && serialRxByte && !setupEndCmd;
  endsequence
  // No setup-end event by pin or register for six cycles.
  sequence quietSeq;
    (!setupEndCmd && !regWr) [*6];
  endsequence

  chk_busy_set: assert property (
    (rxFreeSpace <= 12'd62) [*3] |-> display_busy_out) else $error("busy not set");
  chk_busy_clear: assert property (
    ((rxFreeSpace >= 12'd128) && !initBusy) [*4] |-> !display_busy_out)
    else $error("busy not cleared");
  chk_init_busy: assert property (
    initBusy |-> display_busy_out) else $error("ready during init");
  chk_pend_valid: assert property (
    (serialTxValid || usbTxValid) |-> transmit_pending_out) else $error("pending low");
  chk_lock_take: assert property (
    lockSeq |-> ##2 !usbPathSelected) else $error("serial byte did not lock");
  chk_lock_hold: assert property (
    lockSeq ##1 quietSeq |-> !usbPathSelected) else $error("lock released early");
  chk_usb_unconf: assert property (
    (!usbConfigured) [*3] |-> !usbPathSelected) else $error("usb without config");
  chk_mode_onehot: assert property (
    $onehot(serialMode)) else $error("serial mode not one-hot");
  chk_serial_hold: assert property (
    serialTxValid && !serialTxReady |=> serialTxValid && $stable(serialTxData))
    else $error("serial byte dropped");
endmodule

bind tpsr_top tpsr_monitor i_mon (.ref_clk, .sys_rst, .moduleResetN, .rxFreeSpace, .initBusy,
  .display_busy_out, .transmit_pending_out, .serialTxData, .serialTxValid, .serialTxReady,
  .usbTxValid, .usbPathSelected, .usbConfigured, .serialRxByte, .setupEndCmd, .regWr,
  .serialMode);
`default_nettype wire
